/* pointer_validation_trap_table.sv */
// pointer validation for pointer moves and checks, and trap vector location
`timescale 1ns/10ps
`include "pvtt_cfg.svh"
module pointer_validation_trap_table #(
  parameter int          TAG_W        = 5,
  parameter int          ADDR_W       = 31,
  parameter int          PA_W         = 34,
  parameter logic [7:0]  PVAL_TRAP    = 8'h00,
  parameter logic [7:0]  TAG_TRAP     = 8'h01,
  parameter logic [1:0]  HANDLER_WORD = 2'h0
) (
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic                      valReq,
  input  wire pvtt_pkg::ptr_op_t         valOp,
  input  wire logic                      valInMemory,
  input  wire logic [1:0]                execRing,
  input  wire logic [1:0]                fetchLevel,
  input  wire logic [TAG_W+ADDR_W-1:0]   ptrIn,
  output logic                           resValid,
  output logic [TAG_W+ADDR_W-1:0]        resPtr,
  output logic                           resFault,
  output pvtt_pkg::val_result_t          resFaultKind,
  input  wire logic                      trapReq,
  input  wire pvtt_pkg::trap_class_t     trapClass,
  input  wire logic [1:0]                trapRing,
  input  wire logic [7:0]                trapNum,
  input  wire logic                      tableBaseLoad,
  input  wire logic [PA_W-1:0]           tableBaseIn,
  output logic [PA_W-1:0]                tableBase,
  output logic                           memRdReq,
  output logic [PA_W-1:0]                memRdAddr,
  input  wire logic                      memRdValid,
  input  wire logic [TAG_W+ADDR_W-1:0]   memRdData,
  output logic                           pushReq,
  input  wire logic                      pushAck,
  output logic                           handlerValid,
  output logic [TAG_W+ADDR_W-1:0]        handlerPtr,
  output logic                           statusLoad,
  output logic                           busy
);
  import pvtt_pkg::*;

  localparam int W = TAG_W + ADDR_W;

  ptr_val_if pv ();

  logic          valAccept;
  logic          trapAccept;
  logic          faultNow;
  logic          resValid_q, resValid_d;
  logic [W-1:0]  resPtr_q, resPtr_d;
  logic          resFault_q, resFault_d;
  val_result_t   faultKind_q, faultKind_d;
  trap_state_t   state_q, state_d;
  logic          busy_q, busy_d;
  trap_class_t   cls_q, cls_d;
  logic [1:0]    ring_q, ring_d;
  logic [7:0]    num_q, num_d;
  logic [PA_W-1:0] base_q, base_d;
  logic          rdReq_q, rdReq_d;
  logic [PA_W-1:0] rdAddr_q, rdAddr_d;
  logic          push_q, push_d;
  logic          jump_q, jump_d;
  logic [W-1:0]  handler_q, handler_d;
  logic          status_q, status_d;

  ////////////////////////////////////////////////////////////////////////////
  // pointer validation

  // starting level: register pointers use the executing ring
  assign pv.level    = valInMemory ? fetchLevel : execRing;
  assign pv.execRing = execRing;
  assign pv.tag      = ptrIn[W-1:ADDR_W];

  ptr_tag_check u_ptr_tag_check (
    .v (pv.unit)
  );

  // requests are refused while a trap sequence runs
  assign valAccept  = valReq && !busy_q;
  assign faultNow   = (pv.result == VR_RING_FAULT) || (pv.result == VR_TAG_FAULT);
  // validation wins a simultaneous trap request, which is then refused
  assign trapAccept = trapReq && !busy_q && !valReq;

  // result of a move or a check, one cycle after acceptance
  always_comb begin
    resValid_d  = valAccept && !faultNow;
    resFault_d  = valAccept && faultNow;
    resPtr_d    = resPtr_q;
    faultKind_d = faultKind_q;
    if (valAccept && !faultNow) begin
      resPtr_d = {pv.newTag, ptrIn[ADDR_W-1:0]};
    end
    if (valAccept && faultNow) begin
      faultKind_d = pv.result;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      resValid_q  <= 1'b0;
      resPtr_q    <= '0;
      resFault_q  <= 1'b0;
      faultKind_q <= VR_PASS;
    end else begin
      resValid_q  <= resValid_d;
      resPtr_q    <= resPtr_d;
      resFault_q  <= resFault_d;
      faultKind_q <= faultKind_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trap sequence: table word, vector word, state push, branch

  always_comb begin
    state_d   = state_q;
    cls_d     = cls_q;
    ring_d    = ring_q;
    num_d     = num_q;
    rdReq_d   = rdReq_q;
    rdAddr_d  = rdAddr_q;
    push_d    = push_q;
    jump_d    = 1'b0;
    status_d  = 1'b0;
    handler_d = handler_q;
    base_d    = tableBaseLoad ? tableBaseIn : base_q;
    case (state_q)
      S_IDLE: begin
        if (valAccept && faultNow) begin
          cls_d    = CLS_HARD;
          ring_d   = 2'h0;
          num_d    = (pv.result == VR_RING_FAULT) ? PVAL_TRAP : TAG_TRAP;
          rdReq_d  = 1'b1;
          rdAddr_d = base_q + PA_W'(`IDX_HARD);
          state_d  = S_TABLE;
        end else if (trapAccept) begin
          cls_d    = trapClass;
          ring_d   = trapRing;
          num_d    = trapNum;
          rdReq_d  = 1'b1;
          rdAddr_d = base_q + PA_W'(table_index(trapClass, trapRing));
          state_d  = S_TABLE;
        end
      end
      S_TABLE: begin
        // the set pointer's address field is used as a singleword address
        if (memRdValid) begin
          rdAddr_d = PA_W'(memRdData[ADDR_W-1:0]) + (PA_W'(num_q) << `VEC_SHIFT)
                     + PA_W'(HANDLER_WORD);
          state_d  = S_VEC;
        end
      end
      S_VEC: begin
        if (memRdValid) begin
          handler_d = memRdData;
          rdReq_d   = 1'b0;
          push_d    = 1'b1;
          state_d   = S_PUSH;
        end
      end
      S_PUSH: begin
        if (pushAck) begin
          push_d   = 1'b0;
          jump_d   = 1'b1;
          status_d = (cls_q != CLS_SOFT) && (cls_q != CLS_SELF);
          state_d  = S_JUMP;
        end
      end
      S_JUMP: begin
        state_d = S_IDLE;
      end
      default: begin
        state_d = S_IDLE;
        rdReq_d = 1'b0;
        push_d  = 1'b0;
      end
    endcase
    busy_d = (state_d != S_IDLE);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q   <= S_IDLE;
      busy_q    <= 1'b0;
      cls_q     <= CLS_HARD;
      ring_q    <= 2'h0;
      num_q     <= 8'h00;
      base_q    <= `TBL_BASE_RST;
      rdReq_q   <= 1'b0;
      rdAddr_q  <= '0;
      push_q    <= 1'b0;
      jump_q    <= 1'b0;
      handler_q <= '0;
      status_q  <= 1'b0;
    end else begin
      state_q   <= state_d;
      busy_q    <= busy_d;
      cls_q     <= cls_d;
      ring_q    <= ring_d;
      num_q     <= num_d;
      base_q    <= base_d;
      rdReq_q   <= rdReq_d;
      rdAddr_q  <= rdAddr_d;
      push_q    <= push_d;
      jump_q    <= jump_d;
      handler_q <= handler_d;
      status_q  <= status_d;
    end
  end

  // outputs straight from flops
  assign resValid     = resValid_q;
  assign resPtr       = resPtr_q;
  assign resFault     = resFault_q;
  assign resFaultKind = faultKind_q;
  assign tableBase    = base_q;
  assign memRdReq     = rdReq_q;
  assign memRdAddr    = rdAddr_q;
  assign pushReq      = push_q;
  assign handlerValid = jump_q;
  assign handlerPtr   = handler_q;
  assign statusLoad   = status_q;
  assign busy         = busy_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [4:0] inTag;
  logic [1:0] inLevel;
  assign inTag   = ptrIn[W-1:ADDR_W];
  assign inLevel = valInMemory ? fetchLevel : execRing;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_accept_answers: assert property (valAccept |=> (resValid ^ resFault))
    else $error("accepted pointer got no single answer");
  a_check_answers: assert property (valAccept && valOp == OP_CHECK |=> (resValid ^ resFault))
    else $error("checked pointer got no single answer");
  a_reg_start: assert property (valAccept && !valInMemory && inTag >= 5'h08 && inTag <= 5'h1E
    |=> resValid && resPtr[W-1:ADDR_W] == $past(inTag))
    else $error("register pointer user tag changed");
  a_mem_start: assert property (valAccept && valInMemory && inTag >= 5'h08 && inTag <= 5'h1E
    && fetchLevel > execRing |=> resPtr[W-1:ADDR_W] == 5'h04 + {3'b000, $past(fetchLevel)})
    else $error("memory pointer not promoted to fetch level");
  // table read is checked on the answer cycle, as memory may reply at once
  a_ring_trap: assert property (valAccept && inTag >= 5'h04 && inTag <= 5'h07 && inTag[1:0] < inLevel
    |=> resFault && !resValid && resFaultKind == VR_RING_FAULT && state_q == S_TABLE
    && memRdReq && memRdAddr == $past(base_q) + 34'h8)
    else $error("lower ring tag did not trap");
  a_ring_keep: assert property (valAccept && inTag >= 5'h04 && inTag <= 5'h07 && inTag[1:0] >= inLevel
    |=> resValid && resPtr[W-1:ADDR_W] == $past(inTag))
    else $error("ring tag not kept");
  a_user_keep: assert property (valAccept && inTag >= 5'h08 && inTag <= 5'h1E && inLevel == execRing
    |=> resValid && resPtr[W-1:ADDR_W] == $past(inTag))
    else $error("user tag not kept");
  a_addr_kept: assert property (resValid |-> resPtr[ADDR_W-1:0] == $past(ptrIn[ADDR_W-1:0]))
    else $error("pointer address altered");
  a_soft_index: assert property (trapAccept && trapClass == CLS_SOFT
    |=> memRdReq && memRdAddr == $past(base_q) + 34'h4 + {32'h0, $past(trapRing)})
    else $error("soft trap table word wrong");
  a_exec_index: assert property (trapAccept && trapClass == CLS_EXEC
    |=> memRdAddr == $past(base_q) + 34'hB)
    else $error("executive trap table word wrong");
  a_vec_offset: assert property (state_q == S_TABLE && memRdValid
    |=> memRdAddr == PA_W'($past(memRdData[ADDR_W-1:0])) + {24'h0, num_q, 2'b00}
    + PA_W'(HANDLER_WORD))
    else $error("vector offset wrong");

  sequence s_vecRead;
    state_q == S_VEC && memRdValid;
  endsequence
  sequence s_pushDone;
    pushReq && pushAck;
  endsequence
  a_trap_order: assert property (s_vecRead |=> pushReq && !memRdReq && !handlerValid)
    else $error("state push did not follow vector read");
  a_trap_branch: assert property (s_pushDone |=> handlerValid && !pushReq ##1 !handlerValid && !busy)
    else $error("branch did not follow state push");
  a_priv_class: assert property (handlerValid |-> statusLoad == !(cls_q == CLS_SOFT || cls_q == CLS_SELF))
    else $error("privilege of handler wrong");
endmodule : pointer_validation_trap_table

/* pointer_validation_trap_table_test.sv */
// self-checking bench for pointer validation and trap vector location
`timescale 1ns/10ps
module pointer_validation_trap_table_test;
  import pvtt_pkg::*;

  localparam logic [33:0] BASE = 34'h240000100;

  logic        clk, rstn, valReq, valInMemory, trapReq, tableBaseLoad, memRdValid, pushAck;
  logic        resValid, resFault, memRdReq, pushReq, handlerValid, statusLoad, busy;
  ptr_op_t     valOp;
  trap_class_t trapClass;
  val_result_t resFaultKind;
  logic [1:0]  execRing, fetchLevel, trapRing;
  logic [7:0]  trapNum;
  logic [33:0] tableBaseIn, tableBase, memRdAddr;
  logic [35:0] ptrIn, memRdData, resPtr, handlerPtr;
  int          miscompares, nChecks;

  pointer_validation_trap_table u_pointer_validation_trap_table (
    .clk(clk), .rstn(rstn), .valReq(valReq), .valOp(valOp), .valInMemory(valInMemory),
    .execRing(execRing), .fetchLevel(fetchLevel), .ptrIn(ptrIn), .resValid(resValid),
    .resPtr(resPtr), .resFault(resFault), .resFaultKind(resFaultKind), .trapReq(trapReq),
    .trapClass(trapClass), .trapRing(trapRing), .trapNum(trapNum), .tableBaseLoad(tableBaseLoad),
    .tableBaseIn(tableBaseIn), .tableBase(tableBase), .memRdReq(memRdReq), .memRdAddr(memRdAddr),
    .memRdValid(memRdValid), .memRdData(memRdData), .pushReq(pushReq), .pushAck(pushAck),
    .handlerValid(handlerValid), .handlerPtr(handlerPtr), .statusLoad(statusLoad), .busy(busy)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // clock, 5 ns period
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // verdict, reached from the main sequence or the watchdog
  task automatic printVerdict;
    if (miscompares == 0 && nChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : printVerdict

  // four-state compare so an unknown never matches
  task automatic check(input logic [63:0] seen, input logic [63:0] expd, input string what);
    nChecks++;
    if (seen !== expd) begin
      miscompares++;
      $display("FAIL %0t %s seen %0h expected %0h", $time, what, seen, expd);
    end
  endtask : check

  ////////////////////////////////////////////////////////////////////////////////
  // memory side: answer one read, then release data to a different pattern
  task automatic memAnswer(input logic [33:0] addr, input logic [35:0] data);
    int n;
    n = 0;
    while (memRdReq !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    check(memRdReq, 1, "read request missing");
    check(memRdAddr, addr, "read address");
    @(posedge clk);
    memRdValid <= 1'b1;
    memRdData  <= data;
    @(posedge clk);
    memRdValid <= 1'b0;
    memRdData  <= ~data;
    @(negedge clk);
  endtask : memAnswer

  // table word, vector word, push, then branch
  task automatic trapVectors(input logic [3:0] idx, input logic [7:0] num, input logic st);
    logic [30:0] setAddr;
    logic [35:0] hnd;
    int          n;
    setAddr = 31'h12340000 + {23'h0, idx, 4'h0};
    hnd = {5'h06, 19'h0, idx, num};
    n = 0;
    memAnswer(BASE + {30'h0, idx}, {5'h04, setAddr});
    memAnswer({3'b000, setAddr} + {24'h0, num, 2'b00}, hnd);
    while (pushReq !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    check(pushReq, 1, "push request missing");
    check(handlerValid, 0, "branch before push");
    @(posedge clk);
    pushAck <= 1'b1;
    @(posedge clk);
    pushAck <= 1'b0;
    @(negedge clk);
    check(handlerValid, 1, "no branch");
    check(handlerPtr, hnd, "handler pointer");
    check(statusLoad, st, "status load");
    @(negedge clk);
    check(handlerValid, 0, "branch too long");
    n = 0;
    while (busy !== 1'b0 && n < 10) begin
      @(negedge clk);
      n++;
    end
    check(busy, 0, "busy stuck");
  endtask : trapVectors

  // one trap or interrupt request of a given class
  task automatic trapWalk(input trap_class_t cls, input logic [1:0] ring, input logic [7:0] num,
                          input logic [3:0] idx, input logic st);
    @(posedge clk);
    trapReq   <= 1'b1;
    trapClass <= cls;
    trapRing  <= ring;
    trapNum   <= num;
    @(posedge clk);
    trapReq <= 1'b0;
    @(negedge clk);
    check(busy, 1, "trap not taken");
    trapVectors(idx, num, st);
  endtask : trapWalk

  // one validation; a fault must run the hard trap sequence
  task automatic validate(input ptr_op_t op, input logic inMem, input logic [1:0] ring, input logic [1:0] lvl,
                          input logic [4:0] tag, input logic [4:0] expTag, input val_result_t kind);
    logic [30:0] a;
    a = 31'h5A5A1234 ^ {26'h0, tag};
    @(posedge clk);
    valReq      <= 1'b1;
    valOp       <= op;
    valInMemory <= inMem;
    execRing    <= ring;
    fetchLevel  <= lvl;
    ptrIn       <= {tag, a};
    @(posedge clk);
    valReq <= 1'b0;
    ptrIn  <= ~{tag, a};
    @(negedge clk);
    if (kind == VR_PASS) begin
      check(resValid, 1, "no result");
      check(resFault, 0, "false fault");
      check(resPtr, {expTag, a}, "result pointer");
    end else begin
      check(resFault, 1, "no fault");
      check(resValid, 0, "result on fault");
      check(resFaultKind, kind, "fault kind");
      trapVectors(4'h8, (kind == VR_RING_FAULT) ? 8'h00 : 8'h01, 1'b1);
    end
  endtask : validate

  // validation and trap in one cycle: validation wins, trap dropped
  task automatic valWinsOverTrap;
    @(posedge clk);
    valReq      <= 1'b1;
    trapReq     <= 1'b1;
    valOp       <= OP_CHECK;
    valInMemory <= 1'b0;
    execRing    <= 2'h2;
    ptrIn       <= {5'h06, 31'h00000001};
    trapClass   <= CLS_HARD;
    @(posedge clk);
    valReq  <= 1'b0;
    trapReq <= 1'b0;
    @(negedge clk);
    check(resPtr, {5'h06, 31'h00000001}, "equal ring kept");
    check(memRdReq, 0, "dropped trap ran");
    @(negedge clk);
    check(memRdReq, 0, "dropped trap ran");
  endtask : valWinsOverTrap

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the few hundred cycles needed
  initial begin
    #20000;
    miscompares++;
    printVerdict();
  end

  // main sequence
  initial begin
    {rstn, valReq, valInMemory, trapReq, tableBaseLoad, memRdValid, pushAck} = '0;
    {execRing, fetchLevel, trapRing, trapNum, tableBaseIn, ptrIn, memRdData} = '0;
    valOp = OP_MOVE;
    trapClass = CLS_HARD;
    miscompares = 0;
    nChecks = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check(tableBase, 0, "base after reset");
    @(posedge clk);
    tableBaseLoad <= 1'b1;
    tableBaseIn   <= BASE;
    @(posedge clk);
    tableBaseLoad <= 1'b0;
    tableBaseIn   <= ~BASE;
    @(negedge clk);
    check(tableBase, BASE, "base load");
    validate(OP_MOVE, 1'b1, 2'h0, 2'h3, 5'h08, 5'h07, VR_PASS);
    validate(OP_MOVE, 1'b0, 2'h1, 2'h3, 5'h09, 5'h09, VR_PASS);
    validate(OP_CHECK, 1'b1, 2'h1, 2'h2, 5'h1E, 5'h06, VR_PASS);
    validate(OP_MOVE, 1'b1, 2'h0, 2'h2, 5'h06, 5'h06, VR_PASS);
    validate(OP_MOVE, 1'b1, 2'h0, 2'h1, 5'h07, 5'h07, VR_PASS);
    validate(OP_MOVE, 1'b0, 2'h0, 2'h3, 5'h04, 5'h04, VR_PASS);
    validate(OP_MOVE, 1'b1, 2'h0, 2'h3, 5'h04, 5'h00, VR_RING_FAULT);
    validate(OP_CHECK, 1'b0, 2'h3, 2'h0, 5'h05, 5'h00, VR_RING_FAULT);
    validate(OP_MOVE, 1'b0, 2'h0, 2'h0, 5'h1F, 5'h00, VR_TAG_FAULT);
    validate(OP_MOVE, 1'b0, 2'h0, 2'h0, 5'h01, 5'h01, VR_PASS);
    valWinsOverTrap();
    for (int r = 0; r < 4; r++) begin
      trapWalk(CLS_SELF, 2'(r), 8'(r * 3), 4'(r), 1'b0);
      trapWalk(CLS_SOFT, 2'(r), 8'(255 - r), 4'(4 + r), 1'b0);
    end
    trapWalk(CLS_HARD, 2'h0, 8'h05, 4'h8, 1'b1);
    trapWalk(CLS_IO_INT, 2'h0, 8'h01, 4'h9, 1'b1);
    trapWalk(CLS_CNT_INT, 2'h0, 8'h02, 4'hA, 1'b1);
    trapWalk(CLS_EXEC, 2'h3, 8'h07, 4'hB, 1'b1);
    trapWalk(CLS_GATE, 2'h0, 8'h00, 4'hC, 1'b1);
    trapWalk(CLS_GATE, 2'h3, 8'h10, 4'hD, 1'b1);
    printVerdict();
  end
endmodule : pointer_validation_trap_table_test

/* ptr_tag_check.sv */
// derives the new tag of a moved pointer from its starting validation level
`timescale 1ns/10ps
`include "pvtt_cfg.svh"
module ptr_tag_check (
  ptr_val_if.unit v
);
  import pvtt_pkg::*;

  logic isRing;
  logic isUser;

  // tag classes
  assign isRing = (v.tag >= `TAG_RING_LO) && (v.tag <= `TAG_RING_HI);
  assign isUser = (v.tag >= `TAG_USER_LO) && (v.tag <= `TAG_USER_HI);

  // tag derivation; a lower level than the executing ring never reaches here,
  // since address validation only ever raises it, so that case keeps the tag
  always_comb begin
    v.newTag = v.tag;
    v.result = VR_PASS;
    if (isRing) begin
      if (v.tag[1:0] < v.level) begin
        v.result = VR_RING_FAULT;
      end else begin
        v.result = VR_PASS;
      end
    end else if (isUser) begin
      if (v.level > v.execRing) begin
        v.newTag = `TAG_RING_LO + {3'b000, v.level};
        v.result = VR_PROMOTE;
      end else begin
        v.result = VR_PASS;
      end
    end else if ((v.tag == `TAG_GATE) || (v.tag == `TAG_NIL)) begin
      v.result = VR_PASS;
    end else begin
      v.result = VR_TAG_FAULT; // fault and reserved tags never move
    end
  end
endmodule : ptr_tag_check

/* ptr_val_if.sv */
// carrier between the core and the tag derivation unit
`timescale 1ns/10ps
interface ptr_val_if;
  import pvtt_pkg::*;
  logic        [1:0] level;
  logic        [1:0] execRing;
  logic        [4:0] tag;
  logic        [4:0] newTag;
  val_result_t       result;

  modport core (output level, output execRing, output tag, input newTag, input result);
  modport unit (input level, input execRing, input tag, output newTag, output result);
endinterface : ptr_val_if

/* pvtt_cfg.svh */
// constants for pointer validation and trap table indexing
`ifndef PVTT_CFG_SVH
`define PVTT_CFG_SVH

// pointer tag values
`define TAG_FAULT_LO   5'h00
`define TAG_GATE       5'h01
`define TAG_NIL        5'h02
`define TAG_RESERVED   5'h03
`define TAG_RING_LO    5'h04
`define TAG_RING_HI    5'h07
`define TAG_USER_LO    5'h08
`define TAG_USER_HI    5'h1E
`define TAG_FAULT_HI   5'h1F

// singleword index of each class pointer past the table base
`define IDX_SELF_BASE  4'h0
`define IDX_SOFT_BASE  4'h4
`define IDX_HARD       4'h8
`define IDX_IO_INT     4'h9
`define IDX_CNT_INT    4'hA
`define IDX_EXEC       4'hB
`define IDX_GATE_BASE  4'hC

// each vector is four singlewords long
`define VEC_SHIFT      2

// reset values
`define TBL_BASE_RST   34'h000000000

`endif

/* pvtt_pkg.sv */
// types shared by the pointer validation and trap table logic
package pvtt_pkg;
  `include "pvtt_cfg.svh"

  typedef enum logic [2:0] {
    CLS_SELF    = 3'h0,
    CLS_SOFT    = 3'h1,
    CLS_HARD    = 3'h2,
    CLS_IO_INT  = 3'h3,
    CLS_CNT_INT = 3'h4,
    CLS_EXEC    = 3'h5,
    CLS_GATE    = 3'h6
  } trap_class_t;

  typedef enum logic [1:0] {
    VR_PASS       = 2'h0,
    VR_PROMOTE    = 2'h1,
    VR_RING_FAULT = 2'h2,
    VR_TAG_FAULT  = 2'h3
  } val_result_t;

  typedef enum logic {
    OP_MOVE  = 1'b0,
    OP_CHECK = 1'b1
  } ptr_op_t;

  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_TABLE = 5'b00010,
    S_VEC   = 5'b00100,
    S_PUSH  = 5'b01000,
    S_JUMP  = 5'b10000
  } trap_state_t;

  // table singleword that holds the vector set pointer of a class
  function automatic logic [3:0] table_index(trap_class_t cls, logic [1:0] ring);
    logic [3:0] idx;
    idx = `IDX_HARD;
    case (cls)
      CLS_SELF:    idx = `IDX_SELF_BASE + {2'b00, ring};
      CLS_SOFT:    idx = `IDX_SOFT_BASE + {2'b00, ring};
      CLS_HARD:    idx = `IDX_HARD;
      CLS_IO_INT:  idx = `IDX_IO_INT;
      CLS_CNT_INT: idx = `IDX_CNT_INT;
      CLS_EXEC:    idx = `IDX_EXEC;
      CLS_GATE:    idx = `IDX_GATE_BASE + {3'b000, ring[0]};
      default:     idx = `IDX_HARD;
    endcase
    return idx;
  endfunction : table_index
endpackage : pvtt_pkg
